// File: core/ppt_pkg.sv
package ppt_pkg;
  // ----------------------------------------
  // Register indices, byte address is 4 x index
  // ----------------------------------------
  localparam logic [11:0] IDX_CONTROL_HIGH = 12'h044;
  localparam logic [11:0] IDX_CONTROL_LOW = 12'h045;
  localparam logic [11:0] IDX_COUNTER_HIGH = 12'hfb0;
  localparam logic [11:0] IDX_COUNTER_LOW = 12'hfb1;
  localparam logic [11:0] IDX_PERIOD_HIGH = 12'hfb2;
  localparam logic [11:0] IDX_PERIOD_LOW = 12'hfb3;
  localparam logic [11:0] IDX_WIDTH_HIGH = 12'hfb4;
  localparam logic [11:0] IDX_WIDTH_LOW = 12'hfb5;
  localparam int IDX_LSB = 2;
  localparam int ADDR_W = 14;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [7:0] RST_BUFFER = 8'hff;

  // ----------------------------------------
  // Upper control bits
  // ----------------------------------------
  localparam int CH_COUNT_ENABLE = 7;
  localparam int CH_SOFTWARE_TRIGGER = 6;
  localparam int CH_MODE_SELECT = 5;
  localparam int CH_RETRIGGER_ENABLE = 4;
  localparam int CH_CLOCK_SELECT_HI = 3;
  localparam int CH_CLOCK_SELECT_LO = 1;
  localparam int CH_OUTPUT_MASK_MODE = 0;

  // ----------------------------------------
  // Lower control bits
  // ----------------------------------------
  localparam int CL_TRIGGER_EDGE_HI = 7;
  localparam int CL_TRIGGER_EDGE_LO = 6;
  localparam int CL_IRQ_ENABLE = 5;
  localparam int CL_IRQ_FLAG = 4;
  localparam int CL_IRQ_SOURCE_HI = 3;
  localparam int CL_IRQ_SOURCE_LO = 2;
  localparam int CL_OUTPUT_ENABLE = 1;
  localparam int CL_OUTPUT_POLARITY = 0;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] IRQ_SRC_TRIGGER = 2'h0;
  localparam logic [1:0] IRQ_SRC_BORROW = 2'h1;
  localparam logic [1:0] IRQ_SRC_RISE = 2'h2;
  localparam logic [1:0] IRQ_SRC_BOTH = 2'h3;
  localparam int COUNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;
  localparam int PRESCALE_W = 8;
  localparam logic [COUNT_W-1:0] COUNT_LAST = 16'h0001;
endpackage

// File: core/ppt_prescaler.sv
`timescale 1ns/100ps
module ppt_prescaler #(
  parameter int WIDTH = ppt_pkg::PRESCALE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Source select and tick
  input wire logic [2:0] sel,
  output logic tick
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;

  // ----------------------------------------
  // Divider mask per source
  // ----------------------------------------
  function automatic logic [WIDTH-1:0] div_mask(input logic [2:0] s);
    unique case (s)
      3'h0: div_mask = WIDTH'(8'h00);
      3'h1: div_mask = WIDTH'(8'h01);
      3'h2: div_mask = WIDTH'(8'h03);
      3'h3: div_mask = WIDTH'(8'h07);
      3'h4: div_mask = WIDTH'(8'h0f);
      3'h5: div_mask = WIDTH'(8'h1f);
      3'h6: div_mask = WIDTH'(8'h7f);
      3'h7: div_mask = WIDTH'(8'hff);
    endcase
  endfunction

  always_comb begin
    next_cnt = cnt + WIDTH'(1);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end

  assign tick = ce && ((cnt & div_mask(sel)) == div_mask(sel));
endmodule

// File: core/ppt_top.sv
// Functional notes
// - One 16-bit pulse timer, channel one, with output and trigger pins.
// - Waveform reaches the pulse pin only while output_enable is 1.
// - Pulse pin shared: timer drives it when enabled, else general port.
// - Selected edge on the trigger pin starts a count.
// - Counter value readable as high and low bytes, resets 0, writes ignored.
// - Period buffer bytes read/write, reset to all ones.
// - High-width buffer bytes read/write, reset to all ones.
// - Upper control layout fixed, resets 0; software_trigger always reads 0.
// - Lower control layout fixed, resets 0; irq_flag cleared by writing 0, writing 1 keeps it.
// - Reload from period; high until count equals width, low until one.
// - Count clock picked from eight sources by clock select bits.
// - Reading counter high byte latches low byte for the following read.
// - Period written during counting takes effect at the next reload.
`timescale 1ns/100ps
module ppt_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ppt_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [ppt_pkg::DATA_W-1:0] writedata,
  output logic [ppt_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // Trigger pin
  input wire logic hw_trigger_pin,
  // Pulse pin and general port
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic pulse_out_pin_o,
  output logic pulse_out_pin_oe,
  // Interrupt request level
  output logic irq_req
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic ack;
  logic [7:0] ctl_hi;
  logic [7:0] ctl_lo;
  logic [15:0] period_buf;
  logic [15:0] period_valid;
  logic [15:0] width_buf;
  logic [15:0] width_valid;
  logic width_hi_pend;
  logic [15:0] width_cur;
  logic [15:0] count;
  logic [7:0] cnt_lo_latch;
  logic running;
  logic out_lvl;
  logic [1:0] trg_sync;
  logic trg_prev;
  logic [31:0] rdata;
  logic next_ack;
  logic [7:0] next_ctl_hi;
  logic [7:0] next_ctl_lo;
  logic [15:0] next_period_buf;
  logic [15:0] next_period_valid;
  logic [15:0] next_width_buf;
  logic [15:0] next_width_valid;
  logic next_width_hi_pend;
  logic [15:0] next_width_cur;
  logic [15:0] next_count;
  logic [7:0] next_cnt_lo_latch;
  logic next_running;
  logic next_out_lvl;
  logic [31:0] next_rdata;
  logic tick;
  logic acc;
  logic wr;
  logic rd;
  logic [11:0] idx;
  logic [7:0] wb;
  logic trg_edge;
  logic sw_trig;
  logic start;
  logic borrow;
  logic ev;
  logic wave;

  // ----------------------------------------
  // Count clock prescaler
  // ----------------------------------------
  ppt_prescaler #(.WIDTH(ppt_pkg::PRESCALE_W)) u_prescaler (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .sel(ctl_hi[ppt_pkg::CH_CLOCK_SELECT_HI:ppt_pkg::CH_CLOCK_SELECT_LO]),
    .tick(tick)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign waitrequest = (read || write) && !ack;
  assign acc = (read || write) && ack && ce;
  assign wr = acc && write;
  assign rd = acc && read;
  assign idx = address[ppt_pkg::ADDR_W-1:ppt_pkg::IDX_LSB];
  assign wb = writedata[ppt_pkg::BYTE_W-1:0];
  assign readdata = rdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------
  // Trigger detection
  // ----------------------------------------
  always_comb begin
    unique case (ctl_lo[ppt_pkg::CL_TRIGGER_EDGE_HI:ppt_pkg::CL_TRIGGER_EDGE_LO])
      ppt_pkg::EDGE_NONE: trg_edge = 1'b0;
      ppt_pkg::EDGE_RISE: trg_edge = trg_sync[1] && !trg_prev;
      ppt_pkg::EDGE_FALL: trg_edge = !trg_sync[1] && trg_prev;
      ppt_pkg::EDGE_BOTH: trg_edge = trg_sync[1] != trg_prev;
    endcase
  end

  assign sw_trig = wr && hit(idx, ppt_pkg::IDX_CONTROL_HIGH)
    && wb[ppt_pkg::CH_SOFTWARE_TRIGGER];
  assign start = ctl_hi[ppt_pkg::CH_COUNT_ENABLE] && (sw_trig || trg_edge)
    && (!running || ctl_hi[ppt_pkg::CH_RETRIGGER_ENABLE]);
  assign borrow = running && tick && (count == ppt_pkg::COUNT_LAST);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_ack = (read || write) && !ack;
    next_ctl_hi = ctl_hi;
    next_ctl_lo = ctl_lo;
    next_period_buf = period_buf;
    next_period_valid = period_valid;
    next_width_buf = width_buf;
    next_width_valid = width_valid;
    next_width_hi_pend = width_hi_pend;
    next_width_cur = width_cur;
    next_count = count;
    next_cnt_lo_latch = cnt_lo_latch;
    next_running = running;
    next_out_lvl = out_lvl;
    next_rdata = rdata;
    // Register writes
    if (wr) begin
      if (hit(idx, ppt_pkg::IDX_CONTROL_HIGH)) begin
        next_ctl_hi = wb;
        next_ctl_hi[ppt_pkg::CH_SOFTWARE_TRIGGER] = 1'b0;
      end
      if (hit(idx, ppt_pkg::IDX_CONTROL_LOW)) begin
        next_ctl_lo = wb;
        next_ctl_lo[ppt_pkg::CL_IRQ_FLAG] = ctl_lo[ppt_pkg::CL_IRQ_FLAG]
          && wb[ppt_pkg::CL_IRQ_FLAG];
      end
      if (hit(idx, ppt_pkg::IDX_PERIOD_HIGH)) begin
        next_period_buf[15:8] = wb;
      end
      if (hit(idx, ppt_pkg::IDX_PERIOD_LOW)) begin
        next_period_buf[7:0] = wb;
        next_period_valid = {period_buf[15:8], wb};
      end
      if (hit(idx, ppt_pkg::IDX_WIDTH_HIGH)) begin
        next_width_buf[15:8] = wb;
        next_width_hi_pend = 1'b1;
      end
      if (hit(idx, ppt_pkg::IDX_WIDTH_LOW)) begin
        next_width_buf[7:0] = wb;
        next_width_valid = {width_buf[15:8], wb};
        next_width_hi_pend = 1'b0;
      end
    end
    // Register reads, data ready when waitrequest drops
    if ((read || write) && !ack && ce) begin
      next_rdata = '0;
      if (read) begin
        unique case (1'b1)
          hit(idx, ppt_pkg::IDX_CONTROL_HIGH): begin
            next_rdata[7:0] = ctl_hi & ~(8'h01 << ppt_pkg::CH_SOFTWARE_TRIGGER);
          end
          hit(idx, ppt_pkg::IDX_CONTROL_LOW): next_rdata[7:0] = ctl_lo;
          hit(idx, ppt_pkg::IDX_COUNTER_HIGH): begin
            next_rdata[7:0] = count[15:8];
            next_cnt_lo_latch = count[7:0];
          end
          hit(idx, ppt_pkg::IDX_COUNTER_LOW): next_rdata[7:0] = cnt_lo_latch;
          hit(idx, ppt_pkg::IDX_PERIOD_HIGH): next_rdata[7:0] = period_buf[15:8];
          hit(idx, ppt_pkg::IDX_PERIOD_LOW): next_rdata[7:0] = period_buf[7:0];
          hit(idx, ppt_pkg::IDX_WIDTH_HIGH): next_rdata[7:0] = width_buf[15:8];
          hit(idx, ppt_pkg::IDX_WIDTH_LOW): next_rdata[7:0] = width_buf[7:0];
          default: next_rdata = '0;
        endcase
      end
    end
    // Counter and waveform
    if (!ctl_hi[ppt_pkg::CH_COUNT_ENABLE]) begin
      next_running = 1'b0;
      next_out_lvl = 1'b0;
    end else if (start) begin
      next_running = 1'b1;
      next_count = period_valid;
      next_width_cur = width_valid;
      next_out_lvl = 1'b1;
    end else if (borrow) begin
      if (ctl_hi[ppt_pkg::CH_MODE_SELECT]) begin
        next_running = 1'b0;
        next_out_lvl = 1'b0;
      end else begin
        next_count = period_valid;
        next_width_cur = width_hi_pend ? width_cur : width_valid;
        next_out_lvl = 1'b1;
      end
    end else if (running && tick) begin
      next_count = count - 16'h0001;
      if (count - 16'h0001 == width_cur) begin
        next_out_lvl = 1'b0;
      end
    end
    // Interrupt flag, set wins over clear
    if (ev) begin
      next_ctl_lo[ppt_pkg::CL_IRQ_FLAG] = 1'b1;
    end
  end

  always_comb begin
    unique case (ctl_lo[ppt_pkg::CL_IRQ_SOURCE_HI:ppt_pkg::CL_IRQ_SOURCE_LO])
      ppt_pkg::IRQ_SRC_TRIGGER: ev = start;
      ppt_pkg::IRQ_SRC_BORROW: ev = borrow;
      ppt_pkg::IRQ_SRC_RISE: ev = next_out_lvl && !out_lvl;
      ppt_pkg::IRQ_SRC_BOTH: ev = borrow || (next_out_lvl && !out_lvl);
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack <= 1'b0;
      ctl_hi <= ppt_pkg::RST_CONTROL;
      ctl_lo <= ppt_pkg::RST_CONTROL;
      period_buf <= {ppt_pkg::RST_BUFFER, ppt_pkg::RST_BUFFER};
      period_valid <= {ppt_pkg::RST_BUFFER, ppt_pkg::RST_BUFFER};
      width_buf <= {ppt_pkg::RST_BUFFER, ppt_pkg::RST_BUFFER};
      width_valid <= {ppt_pkg::RST_BUFFER, ppt_pkg::RST_BUFFER};
      width_hi_pend <= 1'b0;
      width_cur <= {ppt_pkg::RST_BUFFER, ppt_pkg::RST_BUFFER};
      count <= {ppt_pkg::RST_COUNTER, ppt_pkg::RST_COUNTER};
      cnt_lo_latch <= ppt_pkg::RST_COUNTER;
      running <= 1'b0;
      out_lvl <= 1'b0;
      trg_sync <= 2'b00;
      trg_prev <= 1'b0;
      rdata <= '0;
    end else if (ce) begin
      ack <= next_ack;
      ctl_hi <= next_ctl_hi;
      ctl_lo <= next_ctl_lo;
      period_buf <= next_period_buf;
      period_valid <= next_period_valid;
      width_buf <= next_width_buf;
      width_valid <= next_width_valid;
      width_hi_pend <= next_width_hi_pend;
      width_cur <= next_width_cur;
      count <= next_count;
      cnt_lo_latch <= next_cnt_lo_latch;
      running <= next_running;
      out_lvl <= next_out_lvl;
      trg_sync <= {trg_sync[0], hw_trigger_pin};
      trg_prev <= trg_sync[1];
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Pin sharing and interrupt
  // ----------------------------------------
  assign wave = (out_lvl && !ctl_hi[ppt_pkg::CH_OUTPUT_MASK_MODE])
    ^ ctl_lo[ppt_pkg::CL_OUTPUT_POLARITY];
  assign pulse_out_pin_o = ctl_lo[ppt_pkg::CL_OUTPUT_ENABLE] ? wave : gpio_out;
  assign pulse_out_pin_oe = ctl_lo[ppt_pkg::CL_OUTPUT_ENABLE] || gpio_oe;
  assign irq_req = ctl_lo[ppt_pkg::CL_IRQ_FLAG] && ctl_lo[ppt_pkg::CL_IRQ_ENABLE];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence hw_rise_s;
    ce && !running && ctl_hi[ppt_pkg::CH_COUNT_ENABLE] && !sw_trig
      && ctl_lo[ppt_pkg::CL_TRIGGER_EDGE_HI:ppt_pkg::CL_TRIGGER_EDGE_LO] == ppt_pkg::EDGE_RISE
      && trg_sync[1] && !trg_prev;
  endsequence
  sequence loaded_s;
    running && out_lvl && count == $past(period_valid);
  endsequence

  pin_enabled_a: assert property (ctl_lo[ppt_pkg::CL_OUTPUT_ENABLE]
    |-> pulse_out_pin_o == wave && pulse_out_pin_oe) else $error("pin not timer");
  pin_released_a: assert property (!ctl_lo[ppt_pkg::CL_OUTPUT_ENABLE]
    |-> pulse_out_pin_o == gpio_out && pulse_out_pin_oe == gpio_oe)
    else $error("pin not port");
  hw_start_a: assert property (hw_rise_s |=> loaded_s)
    else $error("trigger did not start");
  software_trigger_zero_a: assert property (ce && read && !ack
    && hit(idx, ppt_pkg::IDX_CONTROL_HIGH) |=> !readdata[ppt_pkg::CH_SOFTWARE_TRIGGER])
    else $error("trigger bit read 1");
  count_ro_a: assert property (wr && hit(idx, ppt_pkg::IDX_COUNTER_LOW) && !rd
    |=> cnt_lo_latch == $past(cnt_lo_latch)) else $error("counter written");
  low_latch_a: assert property (ce && read && !ack
    && hit(idx, ppt_pkg::IDX_COUNTER_HIGH) |=> cnt_lo_latch == $past(count[7:0]))
    else $error("low byte not latched");
  pwm_reload_a: assert property (borrow && ce && !start
    && ctl_hi[ppt_pkg::CH_COUNT_ENABLE] && !ctl_hi[ppt_pkg::CH_MODE_SELECT]
    |=> count == $past(period_valid) && out_lvl) else $error("no reload");
  width_low_a: assert property (ce && running && tick && !start && !borrow
    && ctl_hi[ppt_pkg::CH_COUNT_ENABLE] && count == width_cur + 16'h0001
    |=> !out_lvl) else $error("output not low at width");
  flag_set_a: assert property (ce && ev |=> ctl_lo[ppt_pkg::CL_IRQ_FLAG])
    else $error("irq flag lost");
  div1_tick_a: assert property (ce
    && ctl_hi[ppt_pkg::CH_CLOCK_SELECT_HI:ppt_pkg::CH_CLOCK_SELECT_LO] == 3'h0 |-> tick)
    else $error("undivided clock missing tick");
endmodule

// File: testbench/ppt_ext_circuit.sv
`timescale 1ns/100ps
module ppt_ext_circuit (
  // Clock
  input wire logic clk,
  // Trigger request from bench
  input wire logic fire,
  output logic trig,
  // Pulse pin as seen on the board
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_level
);
  // ----------------------------------------
  // Trigger source and pulled-up pin
  // ----------------------------------------
  int hold;
  initial begin
    trig = 1'b0;
    hold = 0;
  end
  // Async pin edge, held long enough for the synchroniser
  always @(negedge clk) begin
    if (fire) begin
      trig <= 1'b1;
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 1) begin
        trig <= 1'b0;
      end
    end
  end
  // Undriven pin floats high on the pull-up
  assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule

// File: testbench/tb_pulse_timer_pins_and_regs.sv
`timescale 1ns/100ps
module tb_pulse_timer_pins_and_regs;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, rstn, ce, read, write, waitrequest, hw_trigger_pin, gpio_out, gpio_oe;
  logic pin_o, pin_oe, irq_req, fire, pin_level;
  logic [ppt_pkg::ADDR_W-1:0] address;
  logic [ppt_pkg::DATA_W-1:0] writedata, readdata;
  int mismatches, n_checks, cycles, hc, s;
  logic [7:0] d, d2;
  logic [15:0] v;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0; ce = 1'b1; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    gpio_out = 1'b0; gpio_oe = 1'b0; fire = 1'b0;
    mismatches = 0; n_checks = 0; cycles = 0;
  end
  ppt_top u_ppt_top (.clk(clk), .rstn(rstn), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .hw_trigger_pin(hw_trigger_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pulse_out_pin_o(pin_o), .pulse_out_pin_oe(pin_oe), .irq_req(irq_req));
  ppt_ext_circuit u_ppt_ext_circuit (.clk(clk), .fire(fire), .trig(hw_trigger_pin),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin_level));
  // ----------------------------------------
  // Report, timeout, compares
  // ----------------------------------------
  task final_report;
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: run timed out", $time);
      final_report;
    end
  end
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // Avalon master and pin measurement
  // ----------------------------------------
  task bus_write(input logic [11:0] idx, input logic [7:0] wd);
    @(posedge clk);
    address <= {idx, 2'b00}; writedata <= {24'h000000, wd}; write <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    write <= 1'b0;
  endtask
  task bus_read(input logic [11:0] idx, output logic [7:0] rd);
    @(posedge clk);
    address <= {idx, 2'b00}; read <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata[7:0];
    read <= 1'b0;
  endtask
  task count_high(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (pin_level === 1'b1) c++;
    end
  endtask
  function automatic int div_of(input int sel);
    case (sel)
      0: return 1;
      1: return 2;
      2: return 4;
      3: return 8;
      4: return 16;
      5: return 32;
      6: return 128;
      default: return 256;
    endcase
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset_values;
    bus_read(ppt_pkg::IDX_CONTROL_HIGH, d); chk8(d, 8'h00);
    bus_read(ppt_pkg::IDX_CONTROL_LOW, d); chk8(d, 8'h00);
    bus_read(ppt_pkg::IDX_COUNTER_HIGH, d); chk8(d, 8'h00);
    bus_read(ppt_pkg::IDX_COUNTER_LOW, d); chk8(d, 8'h00);
    bus_read(ppt_pkg::IDX_PERIOD_HIGH, d); chk8(d, 8'hff);
    bus_read(ppt_pkg::IDX_PERIOD_LOW, d); chk8(d, 8'hff);
    bus_read(ppt_pkg::IDX_WIDTH_HIGH, d); chk8(d, 8'hff);
    bus_read(ppt_pkg::IDX_WIDTH_LOW, d); chk8(d, 8'hff);
    chk_bit(pin_oe, 1'b0);
  endtask
  task t_access_kinds;
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h5e);
    bus_read(ppt_pkg::IDX_CONTROL_HIGH, d); chk8(d, 8'h1e);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_CONTROL_LOW, 8'he7);
    bus_read(ppt_pkg::IDX_CONTROL_LOW, d); chk8(d, 8'he7);
    bus_write(ppt_pkg::IDX_COUNTER_HIGH, 8'h55);
    bus_write(ppt_pkg::IDX_COUNTER_LOW, 8'haa);
    bus_read(ppt_pkg::IDX_COUNTER_HIGH, d); chk8(d, 8'h00);
    bus_read(ppt_pkg::IDX_COUNTER_LOW, d); chk8(d, 8'h00);
    bus_write(12'h046, 8'h3c);
    bus_read(12'h046, d); chk8(d, 8'h00);
    bus_write(ppt_pkg::IDX_PERIOD_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_PERIOD_LOW, 8'h06);
    bus_write(ppt_pkg::IDX_WIDTH_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_WIDTH_LOW, 8'h02);
    bus_read(ppt_pkg::IDX_PERIOD_LOW, d); chk8(d, 8'h06);
    bus_read(ppt_pkg::IDX_WIDTH_LOW, d); chk8(d, 8'h02);
    bus_read(ppt_pkg::IDX_WIDTH_HIGH, d); chk8(d, 8'h00);
  endtask
  task t_hw_trigger;
    bus_write(ppt_pkg::IDX_CONTROL_LOW, 8'h42);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h80);
    count_high(12, hc); chk_cnt(hc, 0);
    @(posedge clk); fire <= 1'b1;
    @(posedge clk); fire <= 1'b0;
    repeat (10) @(posedge clk);
    count_high(24, hc); chk_cnt(hc, 16);
  endtask
  task t_clock_select;
    for (s = 0; s < 8; s++) begin
      bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h80 | {4'h0, s[2:0], 1'b0});
      repeat (12 * div_of(s)) @(posedge clk);
      count_high(24 * div_of(s), hc); chk_cnt(hc, 16 * div_of(s));
    end
  endtask
  task t_period_change;
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h80);
    bus_write(ppt_pkg::IDX_PERIOD_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_PERIOD_LOW, 8'h0a);
    repeat (30) @(posedge clk);
    count_high(40, hc); chk_cnt(hc, 32);
  endtask
  task t_counter_latch;
    bus_write(ppt_pkg::IDX_PERIOD_HIGH, 8'h08);
    bus_write(ppt_pkg::IDX_PERIOD_LOW, 8'h00);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h8e);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'hce);
    bus_read(ppt_pkg::IDX_COUNTER_HIGH, d);
    bus_read(ppt_pkg::IDX_COUNTER_LOW, d2);
    v = {d, d2};
    chk_bit(v >= 16'h07fe && v <= 16'h0800, 1'b1);
    @(negedge clk); chk_bit(pin_level, 1'b1);
  endtask
  task t_output_disable;
    bus_write(ppt_pkg::IDX_CONTROL_LOW, 8'h40);
    @(posedge clk); gpio_oe <= 1'b1; gpio_out <= 1'b1;
    @(negedge clk); chk_bit(pin_o, 1'b1); chk_bit(pin_oe, 1'b1);
    @(posedge clk); gpio_out <= 1'b0;
    @(negedge clk); chk_bit(pin_o, 1'b0);
    @(posedge clk); gpio_oe <= 1'b0;
    @(negedge clk); chk_bit(pin_oe, 1'b0); chk_bit(pin_level, 1'b1);
    chk_bit(irq_req, 1'b0);
  endtask
  task t_one_shot_irq;
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_PERIOD_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_PERIOD_LOW, 8'h04);
    bus_write(ppt_pkg::IDX_WIDTH_HIGH, 8'h00);
    bus_write(ppt_pkg::IDX_WIDTH_LOW, 8'h01);
    bus_write(ppt_pkg::IDX_CONTROL_LOW, 8'ha7);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'ha0);
    @(posedge clk); fire <= 1'b1;
    @(posedge clk); fire <= 1'b0;
    count_high(30, hc); chk_cnt(hc, 27);
    chk_bit(irq_req, 1'b1);
    bus_read(ppt_pkg::IDX_CONTROL_LOW, d); chk8(d, 8'hb7);
    bus_write(ppt_pkg::IDX_CONTROL_LOW, 8'h22);
    @(negedge clk); chk_bit(irq_req, 1'b0);
  endtask
  task t_retrigger_mask;
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'hd1);
    @(negedge clk); chk_bit(irq_req, 1'b1);
    bus_write(ppt_pkg::IDX_CONTROL_LOW, 8'h22);
    @(negedge clk); chk_bit(irq_req, 1'b0);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'hd1);
    @(negedge clk); chk_bit(irq_req, 1'b1);
    count_high(16, hc); chk_cnt(hc, 0);
    bus_write(ppt_pkg::IDX_CONTROL_HIGH, 8'h90);
    count_high(16, hc); chk_cnt(hc, 12);
  endtask
  task t_mid_reset;
    @(posedge clk); rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values;
    chk_bit(irq_req, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values;
    t_access_kinds;
    t_hw_trigger;
    t_clock_select;
    t_period_change;
    t_counter_latch;
    t_output_disable;
    t_one_shot_irq;
    t_retrigger_mask;
    t_mid_reset;
    final_report;
  end
endmodule
